// *** dv/osc_wiring_model.sv ***
// wiring model: pull-ups on the open-collector terminals and a form-C relay
`timescale 1ns/1ns
`default_nettype none
module osc_wiring_model (
  // open-collector drives
  input  wire logic outAOut,
  input  wire logic outAOe,
  input  wire logic outBOut,
  input  wire logic outBOe,
  // relay coil
  input  wire logic relayCoil,
  // levels seen by the load
  output logic      termA,
  output logic      termB,
  output logic      relayMakeContact,
  output logic      relayBreakContact
);
  assign termA = outAOe ? outAOut : 1'b1;
  assign termB = outBOe ? outBOut : 1'b1;
  assign relayMakeContact  = relayCoil;
  assign relayBreakContact = !relayCoil;
endmodule // osc_wiring_model
`default_nettype wire

// *** dv/test_output_signal_conditioner.sv ***
// self-checking bench for the output signal conditioner
`timescale 1ns/1ns
`default_nettype none
module test_output_signal_conditioner;
  localparam int unsigned TC = 4;  // short tick so delays finish quickly
  // clock, reset and bus
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [11:0] paddr   = 12'h000;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // status sources
  logic        runMode     = 1'b0;
  logic        alarmActive = 1'b0;
  logic [63:0] statusFlags = 64'h0;
  // pins and wiring levels
  logic        outAOut, outAOe, outBOut, outBOe, relayCoil;
  logic        termA, termB, relayMakeContact, relayBreakContact;
  // bookkeeping
  int          errorCnt = 0;
  int          compares = 0;
  logic [31:0] rd;
  logic        err;

  osc_top #(.TICK_CYCLES(TC)) u_osc_top (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .runMode(runMode),
    .alarmActive(alarmActive), .statusFlags(statusFlags), .outAOut(outAOut),
    .outAOe(outAOe), .outBOut(outBOut), .outBOe(outBOe), .relayCoil(relayCoil));
  osc_wiring_model u_osc_wiring_model (.outAOut(outAOut), .outAOe(outAOe),
    .outBOut(outBOut), .outBOe(outBOe), .relayCoil(relayCoil), .termA(termA),
    .termB(termB), .relayMakeContact(relayMakeContact),
    .relayBreakContact(relayBreakContact));

  // 100 MHz clock
  initial
  begin
    forever #5 clk_sys = !clk_sys;
  end

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // wait n edges, then let their updates land
  task automatic edges(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // one APB transfer; read data and error land in rd and err
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // pready, read data and error are all taken at the completing rising edge
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk_sys);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
      chk(32'h1, 32'h0);
    rd  = prdata;
    err = pslverr;
    // release only after the answer edge, by non-blocking assignment
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // reset values, unmapped and unaligned accesses
  task automatic t_regs;
    int i;
    logic [31:0] exp [10] = '{32'h0, 32'h1, 32'h5, 32'h1, 0, 0, 0, 0, 0, 0};
    chk(relayCoil, 1'b1);
    chk(outAOe, 1'b0);
    for (i = 0; i < 10; i++)
    begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(rd, exp[i]);
    end
    apb(1'b0, 12'h02C, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b0, 12'h002, 32'h0);
    chk(err, 1'b1);
    // status after reset: coil energized, filtered levels and run mode low
    apb(1'b0, osc_pkg::OFS_STAT, 32'h0);
    chk(rd, 32'h8);
    chk(err, 1'b0);
    $display("register test done");
  endtask

  // every code on terminal 11 while terminal 12, set to the next code, stays off; then relay polarity with the run code
  task automatic t_route;
    int n;
    for (n = 0; n < 64; n++)
    begin
      apb(1'b1, osc_pkg::OFS_SEL_A, 32'(n));
      apb(1'b1, osc_pkg::OFS_SEL_B, 32'((n + 1) % 64));
      @(posedge clk_sys);
      statusFlags <= 64'h1 << n;
      runMode     <= (n == 0);
      alarmActive <= (n == 5);
      edges(2);
      chk(outAOe, 1'b1);
      chk(termA, 1'b0);
      chk(termB, 1'b1);
      @(posedge clk_sys);
      statusFlags <= 64'h0;
      runMode     <= 1'b0;
      alarmActive <= 1'b0;
      edges(2);
      chk(outAOe, 1'b0);
    end
    apb(1'b1, osc_pkg::OFS_SEL_R, 32'h0);
    for (n = 0; n < 2; n++)
    begin
      apb(1'b1, osc_pkg::OFS_POL_R, 32'(n));
      @(posedge clk_sys);
      runMode <= 1'b1;
      edges(2);
      chk(relayCoil, n == 0);
      chk(relayMakeContact, n == 0);
      @(posedge clk_sys);
      runMode <= 1'b0;
      edges(2);
      chk(relayCoil, n == 1);
    end
    $display("routing test done");
  endtask

  // on delay of 3 steps: a short pulse is swallowed, a long one delayed
  task automatic t_on;
    apb(1'b1, osc_pkg::OFS_SEL_A, 32'h2);
    apb(1'b1, osc_pkg::OFS_DLY, 32'h3);
    @(posedge clk_sys);
    statusFlags[2] <= 1'b1;
    repeat (11) @(posedge clk_sys);
    statusFlags[2] <= 1'b0;
    repeat (16)
    begin
      edges(1);
      chk(outAOe, 1'b0);
    end
    // a single-cycle pulse is swallowed as well
    @(posedge clk_sys);
    statusFlags[2] <= 1'b1;
    @(posedge clk_sys);
    statusFlags[2] <= 1'b0;
    repeat (4)
    begin
      edges(1);
      chk(outAOe, 1'b0);
    end
    @(posedge clk_sys);
    statusFlags[2] <= 1'b1;
    edges(3 * TC);
    chk(outAOe, 1'b0);
    edges(2);
    chk(outAOe, 1'b1);
    @(posedge clk_sys);
    statusFlags[2] <= 1'b0;
    edges(2);
    chk(outAOe, 1'b0);
    $display("on delay test done");
  endtask

  // off delay of 2 steps: a short gap is bridged, the trailing edge delayed
  task automatic t_off;
    apb(1'b1, osc_pkg::OFS_DLY, 32'h0);
    apb(1'b1, osc_pkg::OFS_DLY + 12'h004, 32'h2);
    @(posedge clk_sys);
    statusFlags[2] <= 1'b1;
    edges(2);
    chk(outAOe, 1'b1);
    @(posedge clk_sys);
    statusFlags[2] <= 1'b0;
    repeat (7) @(posedge clk_sys);
    statusFlags[2] <= 1'b1;
    repeat (10)
    begin
      edges(1);
      chk(outAOe, 1'b1);
    end
    @(posedge clk_sys);
    statusFlags[2] <= 1'b0;
    edges(2 * TC);
    chk(outAOe, 1'b1);
    edges(2);
    chk(outAOe, 1'b0);
    $display("off delay test done");
  endtask

  // relay with both delays and inverted coil
  task automatic t_both;
    apb(1'b1, osc_pkg::OFS_SEL_R, 32'h2);
    apb(1'b1, osc_pkg::OFS_POL_R, 32'h1);
    apb(1'b1, osc_pkg::OFS_DLY + 12'h010, 32'h1);
    apb(1'b1, osc_pkg::OFS_DLY + 12'h014, 32'h2);
    @(posedge clk_sys);
    statusFlags[2] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    statusFlags[2] <= 1'b0;
    repeat (8)
    begin
      edges(1);
      chk(relayCoil, 1'b1);
    end
    @(posedge clk_sys);
    statusFlags[2] <= 1'b1;
    edges(TC);
    chk(relayCoil, 1'b1);
    edges(2);
    chk(relayCoil, 1'b0);
    @(posedge clk_sys);
    statusFlags[2] <= 1'b0;
    edges(2 * TC);
    chk(relayCoil, 1'b0);
    edges(2);
    chk(relayCoil, 1'b1);
    $display("combined delay test done");
  endtask

  // delay settings stop at 100.0 s
  task automatic t_clamp;
    apb(1'b1, osc_pkg::OFS_DLY + 12'h010, 32'h3E9);
    apb(1'b0, osc_pkg::OFS_DLY + 12'h010, 32'h0);
    chk(rd, 32'h3E8);
    $display("clamp test done");
  endtask

  // verdict and end of run
  task automatic testDone;
    $display("comparisons %0d, mismatches %0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    edges(1);
    t_regs();
    t_route();
    t_on();
    t_off();
    t_both();
    t_clamp();
    testDone();
  end

  // watchdog, far beyond the roughly one thousand cycles the tests need
  initial
  begin
    #500_000;
    errorCnt++;
    $display("[ERR] %0t ns: watchdog expired", $time);
    testDone();
  end
endmodule // test_output_signal_conditioner
`default_nettype wire

// *** src/osc_delay_filter.sv ***
// on/off delay filter for one output
`timescale 1ns/1ns
`default_nettype none
module osc_delay_filter #(
  parameter int unsigned TICK_CYCLES = osc_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // source, settings and result
  osc_dly_if.filter dly
);
  logic [osc_pkg::DLY_W-1:0] cnt_q;   // whole steps the source has held
  logic                      filt_q;  // conditioned level
  logic                      tick;    // end of one 0.1 s step

  // source differs from output: a transition is pending
  wire pending = dly.src != filt_q;
  // the delay that governs the pending edge
  wire [osc_pkg::DLY_W-1:0] limit = dly.src ? dly.riseDly : dly.fallDly;
  wire bypass = limit == '0;
  wire done = tick && (cnt_q + osc_pkg::DLY_W'(1) >= limit);

  // step timer runs only while an edge is pending
  osc_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) uTick (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .clear   (!pending),
    .tick    (tick)
  );

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      filt_q <= 1'b0;
      cnt_q  <= '0;
    end
    else if (!pending)
      cnt_q <= '0;
    else if (bypass)
      filt_q <= dly.src;
    else if (done)
    begin
      filt_q <= dly.src;
      cnt_q  <= '0;
    end
    else if (tick)
      cnt_q <= cnt_q + osc_pkg::DLY_W'(1);
  end
  assign dly.filt = filt_q;

  // zero delay follows the source next cycle
  bypass_follow_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pending && bypass |=> filt_q == $past(dly.src))
    else $error("zero delay did not pass source");
  // output rises only from a held high source
  on_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(filt_q) |-> $past(dly.src) && ($past(bypass) || $past(tick)))
    else $error("output rose without held source");
  // output falls only from a held low source
  off_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(filt_q) |-> !$past(dly.src) && ($past(bypass) || $past(tick)))
    else $error("output fell without held source");
  // step count never passes the governing delay
  count_bound_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pending && !bypass |-> cnt_q < limit)
    else $error("step count overran delay");
  // with an on delay set, a single-cycle source pulse never reaches the output
  short_pulse_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !filt_q && !dly.src && dly.riseDly != '0 ##1 dly.src ##1 !dly.src |=> !filt_q)
    else $error("short pulse passed on delay");
  // delayed rise seen
  dly_rise_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(filt_q) && $past(!bypass));
  // suppressed pulse seen
  suppress_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(dly.src) && !filt_q);
endmodule // osc_delay_filter
`default_nettype wire

// *** src/osc_dly_if.sv ***
// carrier between the top and one delay filter
`timescale 1ns/1ns
`default_nettype none
interface osc_dly_if;
  logic                       src;      // unfiltered source level
  logic [osc_pkg::DLY_W-1:0]  riseDly;  // on delay in 0.1 s steps
  logic [osc_pkg::DLY_W-1:0]  fallDly;  // off delay in 0.1 s steps
  logic                       filt;     // conditioned level
  // filter side
  modport filter (input src, input riseDly, input fallDly, output filt);
  // owner side
  modport owner (output src, output riseDly, output fallDly, input filt);
endinterface
`default_nettype wire

// *** src/osc_pkg.sv ***
// constants shared by the output signal conditioner
package osc_pkg;
  // clock rate in kHz and the delay tick period in ms
  localparam int unsigned CLK_KHZ     = 100_000;
  localparam int unsigned TICK_MS     = 100;
  // cycles per 0.1 s delay step, derived from the two figures above
  localparam int unsigned TICK_CYCLES = TICK_MS * CLK_KHZ;
  localparam int          TICK_W      = 24;
  // delay settings count 0.1 s steps, 0 means no delay
  localparam int          DLY_W       = 10;
  localparam logic [9:0]  DLY_MAX     = 10'h3E8;
  localparam logic [9:0]  DLY_RST     = 10'h000;
  // output function codes
  localparam int          SEL_W       = 6;
  localparam int          FUNC_N      = 64;
  localparam logic [5:0]  FUNC_RUN    = 6'h00;
  localparam logic [5:0]  FUNC_ALARM  = 6'h05;
  // reset values of the selectors and the coil polarity
  localparam logic [5:0]  SEL_A_RST   = 6'h00;
  localparam logic [5:0]  SEL_B_RST   = 6'h01;
  localparam logic [5:0]  SEL_R_RST   = 6'h05;
  localparam logic        POL_R_RST   = 1'b1;
  // outputs: 0 = terminal 11, 1 = terminal 12, 2 = relay
  localparam int          OUT_N       = 3;
  localparam int          OUT_RELAY   = 2;
  // APB byte offsets
  localparam int          ADDR_W      = 12;
  localparam logic [11:0] OFS_SEL_A   = 12'h000;
  localparam logic [11:0] OFS_SEL_B   = 12'h004;
  localparam logic [11:0] OFS_SEL_R   = 12'h008;
  localparam logic [11:0] OFS_POL_R   = 12'h00C;
  localparam logic [11:0] OFS_DLY     = 12'h010;
  localparam logic [11:0] OFS_STAT    = 12'h028;
  // register indices returned by the decoder
  localparam logic [3:0]  IDX_POL     = 4'h3;
  localparam logic [3:0]  IDX_DLY     = 4'h4;
  localparam logic [3:0]  IDX_STAT    = 4'hA;
  localparam logic [3:0]  IDX_NONE    = 4'hF;
endpackage

// *** src/osc_tick_gen.sv ***
// restartable 0.1 s step generator
`timescale 1ns/1ns
`default_nettype none
module osc_tick_gen #(
  parameter int unsigned TICK_CYCLES = osc_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // control and step pulse
  input  wire logic clear,
  output logic      tick
);
  logic [osc_pkg::TICK_W-1:0] cnt_q;  // cycles within the current step
  wire  atEnd = cnt_q == osc_pkg::TICK_W'(TICK_CYCLES - 1);
  assign tick = atEnd && !clear;

  // restart on clear so a step always spans the full period
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || clear || atEnd)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + osc_pkg::TICK_W'(1);
  end
endmodule // osc_tick_gen
`default_nettype wire

// *** src/osc_top.sv ***
// output signal conditioner: function routing, delays, coil polarity, APB
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - each output picks its own function
// - relay resets to alarm, inverted coil
// - polarity bit sets coil when OFF
// - relay takes same codes, 00 is run
// - alarm routable to terminal 11
// - rise and fall delays independent
// - on delay swallows short pulses
// - off delay bridges short gaps
// - both delays shift both edges
// - six delays, 0.0 to 100.0 s, reset 0
// - delays count in 0.1 s steps
// - zero delays bypass the filter
// - run function follows run mode
// - open collector pulls low when ON
module osc_top #(
  parameter int unsigned TICK_CYCLES = osc_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // drive status functions
  input  wire logic        runMode,
  input  wire logic        alarmActive,
  input  wire logic [63:0] statusFlags,
  // terminal 11 open collector
  output logic             outAOut,
  output logic             outAOe,
  // terminal 12 open collector
  output logic             outBOut,
  output logic             outBOe,
  // relay coil drive
  output logic             relayCoil
);
  localparam int N  = osc_pkg::OUT_N;
  localparam int R  = osc_pkg::OUT_RELAY;
  localparam int DW = osc_pkg::DLY_W;

  // function selector per output
  logic [osc_pkg::SEL_W-1:0] sel_q [N];
  // relay coil polarity, 1 energizes the coil while OFF
  logic                      polR_q;
  // rise delay at 2k, fall delay at 2k+1
  logic [DW-1:0]             dly_q [2*N];
  // bus answer registers
  logic [31:0]               prdata_q;
  logic                      pready_q;
  logic                      pslverr_q;
  // pin registers
  logic                      outAOe_q;
  logic                      outBOe_q;
  logic                      outLow_q;
  logic                      relayCoil_q;
  // conditioned levels from the filters
  logic [N-1:0]              filt;
  // unfiltered source of each output
  logic [N-1:0]              srcVec;

  // map a byte address to a register index
  function automatic logic [3:0] regIdx(input logic [11:0] a);
    logic [11:0] dOfs;
    dOfs = a - osc_pkg::OFS_DLY;
    if (a[1:0] != 2'b00)
      regIdx = osc_pkg::IDX_NONE;
    else if (a == osc_pkg::OFS_SEL_A)
      regIdx = 4'h0;
    else if (a == osc_pkg::OFS_SEL_B)
      regIdx = 4'h1;
    else if (a == osc_pkg::OFS_SEL_R)
      regIdx = 4'h2;
    else if (a == osc_pkg::OFS_POL_R)
      regIdx = osc_pkg::IDX_POL;
    else if (a >= osc_pkg::OFS_DLY && a < osc_pkg::OFS_STAT)
      regIdx = osc_pkg::IDX_DLY + dOfs[5:2];
    else if (a == osc_pkg::OFS_STAT)
      regIdx = osc_pkg::IDX_STAT;
    else
      regIdx = osc_pkg::IDX_NONE;
  endfunction

  // function vector: code 00 is run mode, code 05 the alarm
  logic [osc_pkg::FUNC_N-1:0] funcVec;
  always_comb
  begin
    funcVec = statusFlags;
    funcVec[osc_pkg::FUNC_RUN]   = runMode;
    funcVec[osc_pkg::FUNC_ALARM] = alarmActive;
  end

  // decoded bus access
  wire [3:0] idx     = regIdx(paddr);
  wire       setup   = psel && !penable;
  wire       access  = psel && penable && pready_q;
  wire       wrEn    = access && pwrite && idx < osc_pkg::IDX_STAT;
  // delay index of the written register
  wire [3:0] dIdx    = idx - osc_pkg::IDX_DLY;
  // writes above 100.0 s clamp to the limit
  wire [DW-1:0] wrDly = (pwdata > 32'(osc_pkg::DLY_MAX)) ?
                        osc_pkg::DLY_MAX : pwdata[DW-1:0];
  // status word: filtered levels, coil drive, run mode
  wire [31:0] statWord = {27'h0, runMode, relayCoil_q, filt};
  // selected register seen by a read
  wire [31:0] rdWord =
    (idx < 4'(N))               ? 32'(sel_q[idx[1:0]]) :
    (idx == osc_pkg::IDX_POL)   ? 32'(polR_q) :
    (idx < osc_pkg::IDX_STAT)   ? 32'(dly_q[dIdx[2:0]]) :
    (idx == osc_pkg::IDX_STAT)  ? statWord : 32'h0000_0000;

  // answer one cycle after setup, so each transfer takes two cycles
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= setup;
      pslverr_q <= setup && idx == osc_pkg::IDX_NONE;
      // read data is sampled in setup and held through access
      if (setup)
        prdata_q <= pwrite ? 32'h0000_0000 : rdWord;
    end
  end

  // relay defaults to alarm, inverted coil
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : gSel
      localparam logic [5:0] SRST = (g == 0) ? osc_pkg::SEL_A_RST :
                                    (g == 1) ? osc_pkg::SEL_B_RST :
                                               osc_pkg::SEL_R_RST;
      // selector register of output g
      always_ff @(posedge clk_sys)
      begin
        if (sys_rst)
          sel_q[g] <= SRST;
        else if (wrEn && idx == 4'(g))
          sel_q[g] <= pwdata[osc_pkg::SEL_W-1:0];
      end
      // any code, alarm included, reaches any output
      assign srcVec[g] = funcVec[sel_q[g]];
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      polR_q <= osc_pkg::POL_R_RST;
    else if (wrEn && idx == osc_pkg::IDX_POL)
      polR_q <= pwdata[0];
  end

  // six delay registers in 0.1 s steps
  generate
    for (g = 0; g < 2 * N; g++)
    begin : gDly
      always_ff @(posedge clk_sys)
      begin
        if (sys_rst)
          dly_q[g] <= osc_pkg::DLY_RST;
        else if (wrEn && idx >= osc_pkg::IDX_DLY && dIdx == 4'(g))
          dly_q[g] <= wrDly;
      end
      // stored delay never exceeds 100.0 s
      dly_range_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        dly_q[g] <= osc_pkg::DLY_MAX)
        else $error("delay setting out of range");
    end
  endgenerate

  // one filter per output, own settings
  osc_dly_if dIf [N] ();
  generate
    for (g = 0; g < N; g++)
    begin : gFlt
      assign dIf[g].src     = srcVec[g];
      assign dIf[g].riseDly = dly_q[2*g];
      assign dIf[g].fallDly = dly_q[2*g+1];
      assign filt[g]        = dIf[g].filt;
      osc_delay_filter #(.TICK_CYCLES(TICK_CYCLES)) uFlt (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .dly     (dIf[g])
      );
    end
  endgenerate

  // pin drivers; one register stage after the filters
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      outAOe_q    <= 1'b0;
      outBOe_q    <= 1'b0;
      outLow_q    <= 1'b0;
      relayCoil_q <= osc_pkg::POL_R_RST;
    end
    else
    begin
      // transistor sinks to ground when ON
      outAOe_q    <= filt[0];
      outBOe_q    <= filt[1];
      outLow_q    <= 1'b0;
      relayCoil_q <= filt[R] ^ polR_q;
    end
  end

  // ports straight from flip-flops
  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign outAOut   = outLow_q;
  assign outAOe    = outAOe_q;
  assign outBOut   = outLow_q;
  assign outBOe    = outBOe_q;
  assign relayCoil = relayCoil_q;

  // relay comes out of reset on alarm with inverted coil
  relay_default_a: assert property (@(posedge clk_sys)
    $fell(sys_rst) |-> sel_q[R] == osc_pkg::FUNC_ALARM && polR_q)
    else $error("relay reset default wrong");
  // coil energized the cycle after filtered level differs from polarity
  coil_polarity_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (filt[R] != polR_q) |=> relayCoil_q)
    else $error("coil drive does not match polarity");
  // code 00 on the relay carries run mode
  relay_run_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    sel_q[R] == osc_pkg::FUNC_RUN |-> srcVec[R] == runMode)
    else $error("relay run routing wrong");
  // alarm on terminal 11 follows the alarm status
  alarm_route_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    sel_q[0] == osc_pkg::FUNC_ALARM |-> srcVec[0] == alarmActive)
    else $error("alarm routing to terminal 11 wrong");
  // open collector enabled one cycle after ON, never driven high
  oc_active_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    filt[0] |=> outAOe_q && !outAOut)
    else $error("open collector not sinking when ON");
  // polarity flips the coil without touching the filtered level
  pol_after_filt_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $stable(filt[R]) && $changed(polR_q) |=> $changed(relayCoil_q))
    else $error("polarity change did not act on coil");
  // every setup is answered in the next cycle
  apb_ready_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    setup |=> pready_q ##1 !pready_q)
    else $error("APB answer not one cycle");
  // relay rerouted to run
  relay_run_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    sel_q[R] == osc_pkg::FUNC_RUN && relayCoil_q);
  // unmapped access seen
  bad_addr_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    pslverr_q && pready_q);
endmodule // osc_top
`default_nettype wire
